/* File: eeprom_cmd.sv */
/*
 Serial EEPROM command interface seen from the memory: frame decoder, write-enable
 latch, self-timed program/erase engine, read shifter and ready/busy reporting.
 Assumes all pins come from the host's domain and are sampled by mclk, which must
 run well above the serial clock.
*/
`timescale 1ns/1ps

// Summary of operation
// - Frame is 9 bits x16, 10 bits x8.
// - Serial input sampled on each clock rise.
// - Output high impedance except read or status.
// - Reselect during cycle shows busy low, ready high.
// - Dummy one bit releases status output.
// - Status release ignored while busy.
// - Read sends leading zero then word MSB first.
// - Read data bits change on clock rise.
// - Write-enable latch cleared at power-up.
// - Latch stays set until disable or power-off.
// - Program commands refused while latch clear.
// - Reads work regardless of latch.
// - Opcodes 10 read, 11 erase, 01 write.
// - Opcode 00 qualified by top address bits.
// - Chip-select fall starts write cycle.
// - Self-timed cycle needs no serial clock.
// - Location auto-cleared before store.
// - Erase sets addressed location to ones.
// - Clear-all sets every location to ones.
// - Fill-all stores data everywhere.
// - Cycles end within 5 ms or 10 ms.
module eeprom_cmd
   import eeprom_pkg::*;
#(
   parameter int PROG_CYC = eeprom_pkg::PROG_CYCLES, // Single-location cycle length
   parameter int ALL_CYC  = eeprom_pkg::ALL_CYCLES   // Whole-array cycle length
) (
   input  wire logic mclk,             // Core clock
   input  wire logic rst_n,            // Asynchronous reset, active low
   input  wire logic chip_select,      // Chip select pin
   input  wire logic serial_clock_in,  // Serial clock pin
   input  wire logic serial_in,        // Serial data in pin
   input  wire logic word_size_select, // Organization select pin
   output wire logic serial_out,       // Serial data out
   output wire logic serial_out_en,    // Output enable, high while driving
   output wire logic cycle_busy        // High while a self-timed cycle runs
);
   import eeprom_pkg::*;

   logic              rst_meta_reg, rst_sync_n;
   logic [3:0]        in_meta_reg, in_sync_reg, in_prev_reg;
   logic              cs_s, sk_s, si_s, org_s;
   logic              sk_rise, cs_rise, cs_fall;
   frame_state_t      state_reg;
   logic [8:0]        hdr_reg;
   logic [4:0]        bit_cnt_reg;
   logic [WORD_W-1:0] data_reg, rd_shift_reg;
   logic              rd_active_reg, rd_bit_reg;
   logic              wel_reg, status_reg, poll_arm_reg;
   job_t              pend_reg, job_reg;
   logic [5:0]        addr_reg, jaddr_reg;
   logic [WORD_W-1:0] jmask_reg, jdata_reg;
   logic              busy_reg, serial_out_reg, serial_out_en_reg;
   logic [CNT_W-1:0]  cyc_cnt_reg;
   logic              hdr_done, start_cyc, job_end, x16;
   logic [4:0]        hdr_len, data_len;
   logic [1:0]        op, ext;
   logic [WORD_W-1:0] mem [WORDS];

   function automatic logic [1:0] op_of(input logic [8:0] h, input logic w16);
      op_of = w16 ? h[7:6] : h[8:7];
   endfunction

   function automatic logic [1:0] ext_of(input logic [8:0] h, input logic w16);
      ext_of = w16 ? h[5:4] : h[6:5];
   endfunction

   function automatic logic [WORD_W-1:0] mask_of(input logic w16, input logic [8:0] h);
      mask_of = w16 ? ERASED_WORD : (h[0] ? HIGH_MASK : LOW_MASK);
   endfunction

   // Reset release
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n   <= rst_meta_reg;
      end
   end

   // Pin synchronisers and edge history
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         in_meta_reg <= 4'h0;
         in_sync_reg <= 4'h0;
         in_prev_reg <= 4'h0;
      end else begin
         in_meta_reg <= {word_size_select, serial_in, serial_clock_in, chip_select};
         in_sync_reg <= in_meta_reg;
         in_prev_reg <= in_sync_reg;
      end
   end

   assign cs_s     = in_sync_reg[0];
   assign sk_s     = in_sync_reg[1];
   assign si_s     = in_sync_reg[2];
   assign org_s    = in_sync_reg[3];
   assign sk_rise  = sk_s && !in_prev_reg[1] && cs_s;
   assign cs_rise  = cs_s && !in_prev_reg[0];
   assign cs_fall  = !cs_s && in_prev_reg[0];
   assign x16      = (org_s == WORD_ORG_SIXTEEN);
   assign hdr_len  = x16 ? 5'(FRAME_LEN_W16 - 1) : 5'(FRAME_LEN_W8 - 1);
   assign data_len = x16 ? 5'(WORD_W) : 5'(BYTE_W);
   assign hdr_done = (state_reg == ST_HDR) && sk_rise && (bit_cnt_reg == hdr_len - 5'd1);
   assign op       = op_of({hdr_reg[7:0], si_s}, x16);
   assign ext      = ext_of({hdr_reg[7:0], si_s}, x16);
   assign start_cyc = cs_fall && (state_reg == ST_DONE) && (pend_reg != JOB_NONE);
   assign job_end  = busy_reg && (cyc_cnt_reg == '0);

   // Frame decoder
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_reg     <= ST_IDLE;
         hdr_reg       <= 9'h000;
         bit_cnt_reg   <= 5'h00;
         data_reg      <= 16'h0000;
         rd_shift_reg  <= 16'h0000;
         rd_active_reg <= 1'b0;
         rd_bit_reg    <= 1'b0;
         wel_reg       <= WEL_RESET;
         pend_reg      <= JOB_NONE;
         addr_reg      <= 6'h00;
         jmask_reg     <= 16'h0000;
      end else if (cs_fall || !cs_s) begin
         state_reg     <= ST_IDLE;
         rd_active_reg <= 1'b0;
         if (cs_fall) begin
            pend_reg <= JOB_NONE;
         end
      end else if (sk_rise) begin
         unique case (state_reg)
            ST_IDLE: begin
               // Busy device takes no new frame
               if (si_s && !busy_reg) begin
                  state_reg   <= ST_HDR;
                  bit_cnt_reg <= 5'h00;
                  hdr_reg     <= 9'h000;
               end
            end
            ST_HDR: begin
               hdr_reg     <= {hdr_reg[7:0], si_s};
               bit_cnt_reg <= bit_cnt_reg + 5'd1;
               if (hdr_done) begin
                  bit_cnt_reg <= 5'h00;
                  addr_reg    <= x16 ? {hdr_reg[4:0], si_s} : hdr_reg[5:0];
                  jmask_reg   <= mask_of(x16, {hdr_reg[7:0], si_s});
                  state_reg   <= ST_DONE;
                  unique case (op)
                     OP_READ: begin
                        state_reg     <= ST_READ;
                        rd_active_reg <= 1'b1;
                        rd_bit_reg    <= 1'b0;
                        rd_shift_reg  <= x16 ? mem[{hdr_reg[4:0], si_s}] :
                                         (si_s ? {mem[hdr_reg[5:0]][15:8], 8'h00}
                                               : {mem[hdr_reg[5:0]][7:0], 8'h00});
                     end
                     OP_ERASE: begin
                        pend_reg <= wel_reg ? JOB_ERASE : JOB_NONE;
                     end
                     OP_WRITE: begin
                        state_reg <= ST_DATA;
                     end
                     OP_EXT: begin
                        unique case (ext)
                           EXT_ENABLE:    wel_reg <= 1'b1;
                           EXT_DISABLE:   wel_reg <= 1'b0;
                           EXT_CLEAR_ALL: pend_reg <= wel_reg ? JOB_CLEAR_ALL : JOB_NONE;
                           EXT_FILL_ALL:  state_reg <= ST_DATA;
                        endcase
                     end
                  endcase
               end
            end
            ST_DATA: begin
               data_reg    <= {data_reg[14:0], si_s};
               bit_cnt_reg <= bit_cnt_reg + 5'd1;
               if (bit_cnt_reg == data_len - 5'd1) begin
                  state_reg <= ST_DONE;
                  if (!wel_reg) begin
                     pend_reg <= JOB_NONE;
                  end else if (op_of(hdr_reg, x16) == OP_WRITE) begin
                     pend_reg <= JOB_WRITE;
                  end else begin
                     pend_reg <= JOB_FILL_ALL;
                     jmask_reg <= ERASED_WORD;
                  end
               end
            end
            ST_READ: begin
               // Next bit goes out on this rise; release after the last
               if (bit_cnt_reg == data_len) begin
                  rd_active_reg <= 1'b0;
                  state_reg     <= ST_DONE;
               end else begin
                  rd_bit_reg   <= rd_shift_reg[15];
                  rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
                  bit_cnt_reg  <= bit_cnt_reg + 5'd1;
               end
            end
            ST_DONE: begin
            end
         endcase
      end
   end

   // Self-timed cycle engine
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         busy_reg    <= 1'b0;
         cyc_cnt_reg <= '0;
         job_reg     <= JOB_NONE;
         jaddr_reg   <= 6'h00;
         jdata_reg   <= 16'h0000;
      end else if (start_cyc) begin
         busy_reg    <= 1'b1;
         job_reg     <= pend_reg;
         jaddr_reg   <= addr_reg;
         jdata_reg   <= x16 ? data_reg : {data_reg[7:0], data_reg[7:0]};
         cyc_cnt_reg <= (pend_reg == JOB_CLEAR_ALL || pend_reg == JOB_FILL_ALL) ?
                        CNT_W'(ALL_CYC - 1) : CNT_W'(PROG_CYC - 1);
      end else if (job_end) begin
         busy_reg <= 1'b0;
         job_reg  <= JOB_NONE;
      end else if (busy_reg) begin
         cyc_cnt_reg <= cyc_cnt_reg - CNT_W'(1);
      end
   end

   // Array: auto-clear at cycle start, store at cycle end
   always_ff @(posedge mclk) begin
      if (start_cyc) begin
         if (pend_reg == JOB_CLEAR_ALL || pend_reg == JOB_FILL_ALL) begin
            for (int i = 0; i < WORDS; i++) begin
               mem[i] <= ERASED_WORD;
            end
         end else begin
            mem[addr_reg] <= mem[addr_reg] | jmask_reg;
         end
      end else if (job_end) begin
         if (job_reg == JOB_FILL_ALL) begin
            for (int i = 0; i < WORDS; i++) begin
               mem[i] <= jdata_reg;
            end
         end else if (job_reg == JOB_WRITE) begin
            mem[jaddr_reg] <= (mem[jaddr_reg] & ~jmask_reg) | (jdata_reg & jmask_reg);
         end
      end
   end

   // Ready/busy status reporting
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         status_reg   <= 1'b0;
         poll_arm_reg <= 1'b0;
      end else if (start_cyc) begin
         poll_arm_reg <= 1'b1;
         status_reg   <= 1'b0;
      end else if (cs_fall) begin
         status_reg <= 1'b0;
         if (status_reg && !busy_reg) begin
            poll_arm_reg <= 1'b0;
         end
      end else if (cs_rise && poll_arm_reg) begin
         status_reg <= 1'b1;
      end else if (sk_rise && si_s && status_reg && !busy_reg) begin
         status_reg   <= 1'b0;
         poll_arm_reg <= 1'b0;
      end
   end

   // Output pin drive
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         serial_out_reg    <= 1'b0;
         serial_out_en_reg <= 1'b0;
      end else if (status_reg) begin
         serial_out_reg    <= !busy_reg;
         serial_out_en_reg <= 1'b1;
      end else if (rd_active_reg) begin
         serial_out_reg    <= rd_bit_reg;
         serial_out_en_reg <= 1'b1;
      end else begin
         serial_out_reg    <= 1'b0;
         serial_out_en_reg <= 1'b0;
      end
   end

   assign serial_out    = serial_out_reg;
   assign serial_out_en = serial_out_en_reg;
   assign cycle_busy    = busy_reg;

   a_hiz_default: assert property (@(posedge mclk) disable iff (!rst_sync_n)
      !status_reg && !rd_active_reg |=> !serial_out_en)
      else $error("output driven outside read or status");
   a_busy_shows_low: assert property (@(posedge mclk) disable iff (!rst_sync_n)
      status_reg && busy_reg && !job_end |=> serial_out_en && !serial_out)
      else $error("busy status not low");
   a_dummy_release: assert property (@(posedge mclk) disable iff (!rst_sync_n)
      sk_rise && si_s && status_reg && !busy_reg && !cs_fall |=> !status_reg ##1 !serial_out_en)
      else $error("dummy one did not release output");
   a_busy_hold_status: assert property (@(posedge mclk) disable iff (!rst_sync_n)
      status_reg && busy_reg && !job_end && !cs_fall && !start_cyc |=> status_reg)
      else $error("status released while busy");
   a_wel_reset: assert property (@(posedge mclk)
      $rose(rst_sync_n) |-> !wel_reg)
      else $error("write enable set after reset");
   a_refuse_locked: assert property (@(posedge mclk) disable iff (!rst_sync_n)
      hdr_done && op == OP_ERASE && !wel_reg |=> pend_reg == JOB_NONE)
      else $error("erase accepted while locked");
   a_lead_zero: assert property (@(posedge mclk) disable iff (!rst_sync_n)
      hdr_done && op == OP_READ |=> rd_active_reg && !rd_bit_reg ##1 serial_out_en && !serial_out)
      else $error("read did not start with zero");
   a_cycle_bound: assert property (@(posedge mclk) disable iff (!rst_sync_n)
      start_cyc |=> busy_reg && cyc_cnt_reg <= CNT_W'(ALL_CYC - 1))
      else $error("cycle length out of bound");
   a_no_sk_needed: assert property (@(posedge mclk) disable iff (!rst_sync_n)
      busy_reg && cyc_cnt_reg != '0 |=> busy_reg && cyc_cnt_reg == $past(cyc_cnt_reg) - CNT_W'(1))
      else $error("cycle stalled");
   a_frame_len: assert property (@(posedge mclk) disable iff (!rst_sync_n)
      state_reg == ST_HDR && sk_rise &&
      bit_cnt_reg == (x16 ? 5'(FRAME_LEN_W16 - 2) : 5'(FRAME_LEN_W8 - 2)) |=> state_reg != ST_HDR)
      else $error("header length wrong");
endmodule // eeprom_cmd

/* File: eeprom_cmd_tb.sv */
/*
 Self-checking bench for the serial EEPROM command block with the host model.
 Assumes short self-timed cycles set by parameters and a 100 MHz core clock.
*/
`timescale 1ns/1ps
module eeprom_cmd_tb;
   import eeprom_pkg::*;
   localparam int P_CYC = 200;
   localparam int A_CYC = 400;
   logic mclk, rst_n, chip_select, serial_clock_in, serial_in, word_size_select;
   logic serial_out, serial_out_en, cycle_busy;
   int   error_cnt = 0;
   int   checked   = 0;
   int   busy_cnt  = 0;
   int   last_len  = 0;
   logic [15:0] w;

   eeprom_cmd #(.PROG_CYC(P_CYC), .ALL_CYC(A_CYC)) dut (
      .mclk(mclk), .rst_n(rst_n), .chip_select(chip_select),
      .serial_clock_in(serial_clock_in), .serial_in(serial_in),
      .word_size_select(word_size_select), .serial_out(serial_out),
      .serial_out_en(serial_out_en), .cycle_busy(cycle_busy));
   host_model host (
      .mclk(mclk), .serial_out(serial_out), .serial_out_en(serial_out_en),
      .chip_select(chip_select), .serial_clock_in(serial_clock_in), .serial_in(serial_in));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Length of the last busy period
   always @(posedge mclk) begin
      if (cycle_busy === 1'b1) busy_cnt <= busy_cnt + 1;
      else begin
         if (busy_cnt != 0) last_len <= busy_cnt;
         busy_cnt <= 0;
      end
   end

   task complete_run;
      if (error_cnt == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [6:0] ext(input logic [1:0] q);
      return {1'b0, q, 4'h0};
   endfunction

   task automatic send(input logic [31:0] v, input int n);
      logic r;
      for (int i = n - 1; i >= 0; i--) host.clk_bit(v[i], r);
   endtask

   task automatic cmd(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d,
                      input int nd);
      host.sel(1'b1);
      if (word_size_select) send({23'h0, 1'b1, op, a[5:0]}, 9);
      else send({22'h0, 1'b1, op, a}, 10);
      if (nd > 0) send({16'h0, d}, nd);
   endtask

   task automatic rd(input logic [6:0] a, input int n, output logic [15:0] v);
      logic r;
      cmd(OP_READ, a, 16'h0000, 0);
      v = 16'h0000;
      for (int i = 0; i <= n; i++) begin
         host.clk_bit(1'b0, r);
         if (i == 0) cmp_bit(r, 1'b0);
         else v[n-i] = r;
      end
      #100;
      cmp_bit(serial_out_en, 1'b0);
      host.sel(1'b0);
   endtask

   task automatic prog(input int len, input logic poll);
      logic r;
      int   i;
      host.sel(1'b0);
      cmp_bit(cycle_busy, 1'b1);
      cmp_bit(serial_out_en, 1'b0);
      if (poll) begin
         host.sel(1'b1);
         #100;
         cmp_bit(serial_out_en, 1'b1);
         cmp_bit(serial_out, 1'b0);
         host.clk_bit(1'b1, r);
         #100;
         cmp_bit(serial_out_en, 1'b1);
      end
      for (i = 0; i < 3000 && cycle_busy === 1'b1; i++) @(posedge mclk);
      if (i == 3000) begin
         error_cnt++;
         complete_run();
      end
      #20;
      cmp_bit(last_len >= len - 1 && last_len <= len + 1, 1'b1);
      if (poll) begin
         cmp_bit(serial_out_en, 1'b1);
         cmp_bit(serial_out, 1'b1);
         host.clk_bit(1'b1, r);
         #100;
         cmp_bit(serial_out_en, 1'b0);
      end
      host.sel(1'b0);
   endtask

   task automatic t_reset;
      cmp_bit(serial_out_en, 1'b0);
      cmp_bit(cycle_busy, 1'b0);
   endtask

   task automatic t_fill;
      cmd(OP_EXT, ext(EXT_ENABLE), 16'h0000, 0);
      host.sel(1'b0);
      cmd(OP_EXT, ext(EXT_FILL_ALL), 16'h1234, 16);
      prog(A_CYC, 1'b0);
      rd(7'h05, 16, w);
      cmp(w, 16'h1234);
      rd(7'h3F, 16, w);
      cmp(w, 16'h1234);
   endtask

   task automatic t_protect;
      logic [1:0] ops[4] = '{OP_WRITE, OP_ERASE, OP_EXT, OP_EXT};
      logic [6:0] adr[4];
      adr = '{7'h05, 7'h05, ext(EXT_CLEAR_ALL), ext(EXT_FILL_ALL)};
      cmd(OP_EXT, ext(EXT_DISABLE), 16'h0000, 0);
      host.sel(1'b0);
      foreach (ops[k]) begin
         cmd(ops[k], adr[k], 16'hBEEF, (k == 1 || k == 2) ? 0 : 16);
         host.sel(1'b0);
         repeat (20) @(posedge mclk);
         cmp_bit(cycle_busy, 1'b0);
      end
      rd(7'h05, 16, w);
      cmp(w, 16'h1234);
   endtask

   task automatic t_write;
      cmd(OP_EXT, ext(EXT_ENABLE), 16'h0000, 0);
      host.sel(1'b0);
      cmd(OP_WRITE, 7'h05, 16'hA5C3, 16);
      prog(P_CYC, 1'b1);
      rd(7'h05, 16, w);
      cmp(w, 16'hA5C3);
   endtask

   task automatic t_erase;
      cmd(OP_ERASE, 7'h05, 16'h0000, 0);
      prog(P_CYC, 1'b0);
      rd(7'h05, 16, w);
      cmp(w, 16'hFFFF);
      rd(7'h06, 16, w);
      cmp(w, 16'h1234);
   endtask

   task automatic t_byte;
      word_size_select = WORD_ORG_EIGHT;
      cmd(OP_WRITE, 7'h0B, 16'h005A, 8);
      prog(P_CYC, 1'b0);
      rd(7'h0B, 8, w);
      cmp(w, 16'h005A);
      rd(7'h0A, 8, w);
      cmp(w, 16'h00FF);
      word_size_select = WORD_ORG_SIXTEEN;
      rd(7'h05, 16, w);
      cmp(w, 16'h5AFF);
   endtask

   task automatic t_partial;
      host.sel(1'b1);
      send({26'h0, 1'b1, OP_WRITE, 3'b101}, 6);
      host.sel(1'b0);
      repeat (20) @(posedge mclk);
      cmp_bit(cycle_busy, 1'b0);
      rd(7'h05, 16, w);
      cmp(w, 16'h5AFF);
   endtask

   task automatic t_clear;
      cmd(OP_EXT, ext(EXT_CLEAR_ALL), 16'h0000, 0);
      prog(A_CYC, 1'b0);
      rd(7'h00, 16, w);
      cmp(w, 16'hFFFF);
      rd(7'h3F, 16, w);
      cmp(w, 16'hFFFF);
   endtask

   // Mid-run reset with the latch set; memory must survive, latch must not
   task automatic t_power;
      @(posedge mclk);
      #1;
      rst_n = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      repeat (10) @(posedge mclk);
      cmp_bit(serial_out_en, 1'b0);
      cmp_bit(cycle_busy, 1'b0);
      cmd(OP_WRITE, 7'h00, 16'h0F0F, 16);
      host.sel(1'b0);
      repeat (20) @(posedge mclk);
      cmp_bit(cycle_busy, 1'b0);
      rd(7'h00, 16, w);
      cmp(w, 16'hFFFF);
   endtask

   initial begin
      rst_n = 1'b0;
      word_size_select = WORD_ORG_SIXTEEN;
      repeat (8) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      repeat (10) @(posedge mclk);
      t_reset();
      t_fill();
      t_protect();
      t_write();
      t_erase();
      t_byte();
      t_partial();
      t_clear();
      t_power();
      complete_run();
   end
endmodule // eeprom_cmd_tb

/* File: eeprom_pkg.sv */
/*
 Constants, encodings and state types of the serial EEPROM command block.
 Assumes a 100 MHz core clock; all counts are derived from that rate.
*/
package eeprom_pkg;
   // Core clock and self-timed cycle lengths
   localparam int MCLK_HZ        = 100_000_000;
   localparam int PROG_TIME_MS   = 5;
   localparam int ALL_TIME_MS    = 10;
   localparam int PROG_CYCLES    = PROG_TIME_MS * (MCLK_HZ / 1000);
   localparam int ALL_CYCLES     = ALL_TIME_MS * (MCLK_HZ / 1000);
   localparam int CNT_W          = 20;

   // Array shape
   localparam int WORDS          = 64;
   localparam int WORD_W         = 16;
   localparam int BYTE_W         = 8;

   // Frame lengths including the start bit
   localparam int FRAME_LEN_W16  = 9;
   localparam int FRAME_LEN_W8   = 10;

   // Organization select levels
   localparam logic WORD_ORG_SIXTEEN = 1'b1;
   localparam logic WORD_ORG_EIGHT   = 1'b0;

   // Opcodes and opcode-00 qualifiers
   localparam logic [1:0] OP_READ       = 2'h2;
   localparam logic [1:0] OP_ERASE      = 2'h3;
   localparam logic [1:0] OP_WRITE      = 2'h1;
   localparam logic [1:0] OP_EXT        = 2'h0;
   localparam logic [1:0] EXT_ENABLE    = 2'h3;
   localparam logic [1:0] EXT_DISABLE   = 2'h0;
   localparam logic [1:0] EXT_CLEAR_ALL = 2'h2;
   localparam logic [1:0] EXT_FILL_ALL  = 2'h1;

   // Reset, erased and byte-mask values
   localparam logic WEL_RESET = 1'b0;
   localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;
   localparam logic [WORD_W-1:0] LOW_MASK    = 16'h00FF;
   localparam logic [WORD_W-1:0] HIGH_MASK   = 16'hFF00;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HDR  = 3'b001,
      ST_DATA = 3'b010,
      ST_READ = 3'b011,
      ST_DONE = 3'b100
   } frame_state_t;

   typedef enum logic [2:0] {
      JOB_NONE      = 3'b000,
      JOB_WRITE     = 3'b001,
      JOB_ERASE     = 3'b010,
      JOB_CLEAR_ALL = 3'b011,
      JOB_FILL_ALL  = 3'b100
   } job_t;
endpackage

/* File: host_model.sv */
/*
 Behavioural host for the serial EEPROM block: drives select, serial clock and data.
 Assumes the bench calls its tasks one at a time; the serial clock runs only in frames.
*/
`timescale 1ns/1ps
module host_model (
   input  wire logic mclk,            // Core clock, for alignment
   input  wire logic serial_out,      // Device data out
   input  wire logic serial_out_en,   // Device output enable
   output logic      chip_select,     // Select to device
   output logic      serial_clock_in, // Serial clock to device
   output logic      serial_in        // Serial data to device
);
   logic last_reg = 1'b0;
   logic line;

   // Released line shows the inverse of its last driven level
   always @(posedge mclk) begin
      if (serial_out_en) last_reg <= serial_out;
   end
   assign line = serial_out_en ? serial_out : ~last_reg;

   initial begin
      chip_select     = 1'b0;
      serial_clock_in = 1'b0;
      serial_in       = 1'b0;
   end

   // Every select change is held for the minimum deselect time
   task sel(input logic v);
      @(posedge mclk);
      #1;
      chip_select = v;
      #250;
   endtask

   // One 125 ns serial bit; samples the line just before the rise
   task clk_bit(input logic b, output logic r);
      serial_in = b;
      #62.5;
      r = line;
      serial_clock_in = 1'b1;
      #62.5;
      serial_clock_in = 1'b0;
   endtask
endmodule // host_model
